// File: src/itp_pkg.sv
// Shared constants, kinds and helper functions for the interrupt type and priority logic.
// Assumes one system clock and a core that acknowledges one presented request at a time.
package itp_pkg;

  // ****************************************************************
  // Sizes and vectors
  // ****************************************************************
  localparam int          ITP_NUM_SRC        = 10;
  localparam int          ITP_SRC_W          = 4;
  localparam int          ITP_VEC_W          = 16;
  localparam int          ITP_PRIO_LOW_W     = 8;
  localparam int          ITP_PRIO_HIGH_W    = 2;
  localparam int          ITP_NEST_DEPTH     = 8;
  localparam logic [15:0] ITP_VEC_NMI        = 16'h0004;
  localparam logic [15:0] ITP_VEC_TRAP       = 16'h003E;
  localparam logic [15:0] ITP_VEC_MASK_BASE  = 16'h0004;
  localparam int          ITP_VEC_SHIFT      = 1;
  localparam int          ITP_WDT_SRC        = 0;
  localparam logic [9:0]  ITP_FLAGS_RST      = 10'h000;
  localparam logic [15:0] ITP_VEC_RST        = 16'h0000;

  // Kind of the presented or in-service interrupt.
  typedef enum logic [1:0] {
    ITP_KIND_NMI,
    ITP_KIND_TRAP,
    ITP_KIND_HIGH,
    ITP_KIND_LOW
  } itp_kind_t;

  // Lowest set index wins, so source 0 outranks source 9.
  function automatic logic [3:0] itp_first(input logic [9:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = ITP_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Maskable vectors are spaced one word apart above the base.
  function automatic logic [15:0] itp_mask_vector(input logic [3:0] idx);
    return ITP_VEC_MASK_BASE + (16'(idx) << ITP_VEC_SHIFT);
  endfunction

endpackage

// File: src/itp_arb_if.sv
// Bundle between the top and the group arbiter.
// Assumes both ends sit in the same clock domain; clk and rst are copies of the top's, the rest is combinational.
`timescale 1ns/1ps
interface itp_arb_if;
  logic       clk;
  logic       rst;
  logic [9:0] flags;
  logic [9:0] mask;
  logic [9:0] low_grp;
  logic       allow_high;
  logic       allow_low;
  logic       sel_valid;
  logic       sel_high;
  logic [3:0] sel_idx;

  modport arb  (input clk, rst, flags, mask, low_grp, allow_high, allow_low, output sel_valid, sel_high, sel_idx);
  modport user (output clk, rst, flags, mask, low_grp, allow_high, allow_low, input sel_valid, sel_high, sel_idx);
endinterface

// File: src/itp_arbiter.sv
// Group arbiter for the maskable sources: high group first, then fixed index order.
// Assumes the caller has already folded the in-service state into the allow inputs.
`timescale 1ns/1ps
module itp_arbiter
  import itp_pkg::*;
(
  itp_arb_if.arb bus
);

  logic [9:0] elig_high;
  logic [9:0] elig_low;

  // ****************************************************************
  // Eligibility and selection
  // ****************************************************************
  // A masked flag never reaches the selection.
  assign elig_high = bus.flags & ~bus.mask & ~bus.low_grp & {10{bus.allow_high}};
  assign elig_low  = bus.flags & ~bus.mask & bus.low_grp & {10{bus.allow_low}};

  // The high group is always looked at first, the index breaks ties.
  always_comb begin
    bus.sel_valid = (elig_high != '0) || (elig_low != '0);
    bus.sel_high  = (elig_high != '0);
    bus.sel_idx   = (elig_high != '0) ? itp_first(elig_high) : itp_first(elig_low);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // The selection is combinational, so it is sampled on the system clock carried by the bundle.
  a_low_yields: assert property (@(posedge bus.clk) disable iff (bus.rst)
    bus.sel_valid && !bus.sel_high |-> elig_high == '0)
    else $error("low group selected while a high request was eligible");
  a_order_lowest: assert property (@(posedge bus.clk) disable iff (bus.rst)
    bus.sel_valid |-> (((bus.sel_high ? elig_high : elig_low) & ((10'h001 << bus.sel_idx) - 10'h001)) == '0))
    else $error("selected index is not the lowest in its group");

endmodule // itp_arbiter

// File: src/itp_top.sv
// Interrupt type and priority logic: watchdog non-maskable, ten maskable sources, software trap.
// Assumes request inputs are one-cycle pulses synchronous to clk_sys and that the core
// pulses int_ack to take the presented request and int_return when a handler returns.
`timescale 1ns/1ps

// Behaviour
// - The watchdog non-maskable request is presented even when the core has interrupts disabled.
// - The non-maskable request skips group arbitration and beats every maskable or pending request.
// - A pending non-maskable request raises standby release so a halted core wakes.
// - The only non-maskable source is the watchdog overflow.
// - Each maskable request is gated by its own mask flag and is never presented while masked.
// - Each maskable source belongs to the high or the low group by its priority-group flag bit.
// - A high-group request may preempt a low-group handler, and such nesting goes only one level deep.
// - Simultaneous requests in one group are resolved by a fixed source order.
// - Any pending unmasked maskable request raises standby release.
// - There are ten maskable inputs, four from pin or timer edges and six from internal units.
// - The software trap instruction raises an interrupt through its own dedicated vector.
// - The software trap is taken even when interrupts are disabled.
// - The software trap skips group arbitration and is not blocked by any in-service state.
// - The fixed order numbers sources 0 to 9, with 0 highest and 9 lowest.
// - The software trap uses vector 003EH and the watchdog non-maskable request vector 0004H.
// - A request flag is set when its request occurs and cleared on acknowledge or reset.
module itp_top
  import itp_pkg::*;
#(
  parameter int NEST_DEPTH = ITP_NEST_DEPTH
) (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 wdt_overflow,
  input  wire logic                 wdt_nmi_mode,
  input  wire logic [9:0]           maskable_req,
  input  wire logic [9:0]           mask_flags,
  input  wire logic [7:0]           priority_group_flags_low,
  input  wire logic [1:0]           priority_group_flags_high,
  input  wire logic                 int_enable,
  input  wire logic                 software_trap_instruction,
  input  wire logic                 int_ack,
  input  wire logic                 int_return,
  output logic                      int_valid,
  output itp_kind_t                 int_kind,
  output logic [3:0]                int_src,
  output logic [15:0]               int_vector,
  output logic                      standby_release
);

  localparam int SP_W = $clog2(NEST_DEPTH + 1);

  logic [9:0]                  req_flag_reg,   req_flag_next;
  logic                        nmi_pend_reg,   nmi_pend_next;
  logic                        trap_pend_reg,  trap_pend_next;
  itp_kind_t [NEST_DEPTH-1:0]  stack_reg,      stack_next;
  logic [SP_W-1:0]             sp_reg,         sp_next;
  logic                        pres_valid_reg, pres_valid_next;
  itp_kind_t                   pres_kind_reg,  pres_kind_next;
  logic [3:0]                  pres_idx_reg,   pres_idx_next;
  logic [15:0]                 vector_reg,     vector_next;
  logic                        standby_reg,    standby_next;
  logic [SP_W-1:0]             sp_pop;
  logic                        ack_take;
  logic                        ack_maskable;
  logic [9:0]                  ack_clr;
  logic [9:0]                  mask_set;
  logic [9:0]                  mask_d_reg;

  itp_arb_if arb_bus ();

  // True when any live stack level holds the given kind.
  function automatic logic in_service(input itp_kind_t [NEST_DEPTH-1:0] st, input logic [SP_W-1:0] sp,
                                      input itp_kind_t k);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NEST_DEPTH; i++) begin
      if ((SP_W'(i) < sp) && (st[i] == k)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ****************************************************************
  // Request flags
  // ****************************************************************
  // The acknowledge refers to what is presented in its own cycle (the pres registers), so flags and presentation agree.
  always_comb begin
    ack_take     = int_ack && pres_valid_reg;
    ack_maskable = ack_take && ((pres_kind_reg == ITP_KIND_HIGH) || (pres_kind_reg == ITP_KIND_LOW));
    ack_clr      = '0;
    if (ack_maskable) begin
      ack_clr[pres_idx_reg] = 1'b1;
    end
    // In interval mode the watchdog joins source 0; all ten inputs feed the flags.
    mask_set       = maskable_req | (10'(wdt_overflow & ~wdt_nmi_mode) << ITP_WDT_SRC);
    // A new request in the acknowledge cycle survives the clear.
    req_flag_next  = (req_flag_reg & ~ack_clr) | mask_set;
    // The watchdog in watchdog mode is the sole non-maskable source.
    nmi_pend_next  = (nmi_pend_reg & ~(ack_take && (pres_kind_reg == ITP_KIND_NMI))) |
                     (wdt_overflow & wdt_nmi_mode);
    trap_pend_next = (trap_pend_reg & ~(ack_take && (pres_kind_reg == ITP_KIND_TRAP))) |
                     software_trap_instruction;
  end

  // ****************************************************************
  // In-service stack
  // ****************************************************************
  // A return pops first, so a same-cycle acknowledge reuses the freed level.
  // Pushes beyond the depth are dropped; software must bound its nesting.
  always_comb begin
    stack_next = stack_reg;
    sp_pop     = sp_reg;
    if (int_return && (sp_reg != '0)) begin
      sp_pop = sp_reg - SP_W'(1);
    end
    sp_next = sp_pop;
    if (ack_take && (sp_pop < SP_W'(NEST_DEPTH))) begin
      stack_next[sp_pop] = pres_kind_reg;
      sp_next            = sp_pop + SP_W'(1);
    end
  end

  // ****************************************************************
  // Arbitration and presentation
  // ****************************************************************
  // High requests are allowed over a low handler but not over another high one.
  assign arb_bus.flags      = req_flag_next;
  assign arb_bus.mask       = mask_flags;
  assign arb_bus.low_grp    = {priority_group_flags_high, priority_group_flags_low};
  assign arb_bus.allow_high = int_enable && !in_service(stack_next, sp_next, ITP_KIND_HIGH);
  assign arb_bus.allow_low  = arb_bus.allow_high && !in_service(stack_next, sp_next, ITP_KIND_LOW);
  assign arb_bus.clk        = clk_sys;
  assign arb_bus.rst        = sys_rst;

  itp_arbiter u_arbiter (
    .bus (arb_bus.arb)
  );

  // The non-maskable and trap requests ignore enable and in-service state.
  always_comb begin
    pres_valid_next = 1'b1;
    pres_kind_next  = ITP_KIND_NMI;
    pres_idx_next   = 4'h0;
    vector_next     = ITP_VEC_NMI;
    if (nmi_pend_next) begin
      pres_kind_next = ITP_KIND_NMI;
    end else if (trap_pend_next) begin
      pres_kind_next = ITP_KIND_TRAP;
      vector_next    = ITP_VEC_TRAP;
    end else if (arb_bus.sel_valid) begin
      pres_kind_next = arb_bus.sel_high ? ITP_KIND_HIGH : ITP_KIND_LOW;
      pres_idx_next  = arb_bus.sel_idx;
      vector_next    = itp_mask_vector(arb_bus.sel_idx);
    end else begin
      pres_valid_next = 1'b0;
      vector_next     = ITP_VEC_RST;
    end
    // Standby release ignores enable so a halted core always wakes.
    standby_next = nmi_pend_next || ((req_flag_next & ~mask_flags) != '0);
  end

  // Registers only.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      req_flag_reg   <= ITP_FLAGS_RST;
      nmi_pend_reg   <= 1'b0;
      trap_pend_reg  <= 1'b0;
      stack_reg      <= '{default: ITP_KIND_NMI};
      sp_reg         <= '0;
      pres_valid_reg <= 1'b0;
      pres_kind_reg  <= ITP_KIND_NMI;
      pres_idx_reg   <= 4'h0;
      vector_reg     <= ITP_VEC_RST;
      standby_reg    <= 1'b0;
      mask_d_reg     <= ITP_FLAGS_RST;
    end else begin
      req_flag_reg   <= req_flag_next;
      nmi_pend_reg   <= nmi_pend_next;
      trap_pend_reg  <= trap_pend_next;
      stack_reg      <= stack_next;
      sp_reg         <= sp_next;
      pres_valid_reg <= pres_valid_next;
      pres_kind_reg  <= pres_kind_next;
      pres_idx_reg   <= pres_idx_next;
      vector_reg     <= vector_next;
      standby_reg    <= standby_next;
      mask_d_reg     <= mask_flags;
    end
  end

  assign int_valid       = pres_valid_reg;
  assign int_kind        = pres_kind_reg;
  assign int_src         = pres_idx_reg;
  assign int_vector      = vector_reg;
  assign standby_release = standby_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_nmi_always_wins: assert property (nmi_pend_reg |-> int_valid && int_kind == ITP_KIND_NMI)
    else $error("pending non-maskable request not presented first");
  a_nmi_no_enable: assert property (wdt_overflow && wdt_nmi_mode && !int_enable |=> int_valid && int_kind == ITP_KIND_NMI)
    else $error("non-maskable request lost while disabled");
  a_vector_fixed: assert property (int_valid && int_kind == ITP_KIND_NMI |-> int_vector == 16'h0004)
    else $error("wrong non-maskable vector");
  a_trap_taken: assert property (software_trap_instruction && !nmi_pend_next |=>
    int_valid && int_kind == ITP_KIND_TRAP && int_vector == 16'h003E)
    else $error("software trap not presented with its vector");
  a_mask_gate: assert property (int_valid && (int_kind == ITP_KIND_HIGH || int_kind == ITP_KIND_LOW) |->
    !mask_d_reg[int_src] && int_vector == itp_mask_vector(int_src))
    else $error("masked source presented or wrong maskable vector");
  a_flag_held: assert property (1'b1 |=> (($past(req_flag_reg) & ~req_flag_reg) == '0) ||
    ($past(int_ack && int_valid) && (($past(req_flag_reg) & ~req_flag_reg) == (10'h001 << $past(int_src)))))
    else $error("request flag dropped without acknowledge");
  a_standby_wake: assert property ((nmi_pend_reg || (req_flag_reg & ~mask_d_reg) != '0) |-> standby_release)
    else $error("standby release missing for a pending request");
  a_low_blocked: assert property (int_valid && int_kind == ITP_KIND_LOW |->
    !in_service(stack_reg, sp_reg, ITP_KIND_LOW) && !in_service(stack_reg, sp_reg, ITP_KIND_HIGH))
    else $error("low request presented during a maskable handler");
  a_high_over_high: assert property (int_valid && int_kind == ITP_KIND_HIGH |-> !in_service(stack_reg, sp_reg, ITP_KIND_HIGH))
    else $error("high request presented during a high handler");

  c_high_nests_low: cover property (in_service(stack_reg, sp_reg, ITP_KIND_LOW) && int_valid && int_kind == ITP_KIND_HIGH ##1 int_ack);
  c_nmi_preempts: cover property (int_valid && int_kind == ITP_KIND_LOW ##1 int_valid && int_kind == ITP_KIND_NMI);
  c_trap_disabled: cover property (!int_enable && int_valid && int_kind == ITP_KIND_TRAP ##1 int_ack);

endmodule // itp_top

// File: verification/itp_core_model.sv
// Behavioural model of the processor core that takes presented interrupts.
// Assumes the interrupt logic presents one request at a time on clk_sys.
`timescale 1ns/1ps
module itp_core_model (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       int_valid,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_wait,
  input  wire logic       ret_req,
  output logic            int_ack,
  output logic            int_return
);
  // ****************************************************************
  // Acknowledge timing
  // ****************************************************************
  logic [3:0] wait_reg;
  logic [3:0] wait_next;
  logic       ack_next;

  // The core waits ack_wait cycles of a standing request, then pulses one acknowledge.
  // It never acknowledges without a presented request, so a refused acknowledge never occurs.
  always_comb begin
    ack_next  = ack_en && int_valid && !int_ack && (wait_reg >= ack_wait);
    wait_next = (int_valid && !int_ack && !ack_next) ? wait_reg + 4'h1 : 4'h0;
  end

  // State is only registered here.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      int_ack  <= 1'b0;
      wait_reg <= 4'h0;
    end else begin
      int_ack  <= ack_next;
      wait_reg <= wait_next;
    end
  end

  // Handler return is a single pulse requested by the bench.
  assign int_return = ret_req;
endmodule // itp_core_model

// File: verification/itp_top_tb.sv
// Self-checking bench for the interrupt type and priority logic.
// Assumes itp_top and the core model; all stimulus is applied by NBA at rising edges, except the last ack_wait reset in test_nmi_trap, 1 ns later.
`timescale 1ns/1ps
`define CHK(what, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, e, g); end end
module itp_top_tb
  import itp_pkg::*;
;
  logic clk_sys = 1'b0, sys_rst = 1'b1, wdt_overflow = 1'b0, wdt_nmi_mode = 1'b0;
  logic [9:0] maskable_req = 10'h000, mask_flags = 10'h000;
  logic [7:0] priority_group_flags_low = 8'h00;
  logic [1:0] priority_group_flags_high = 2'h0;
  logic int_enable = 1'b1, software_trap_instruction = 1'b0, int_ack, int_return;
  logic ack_en = 1'b0, ret_req = 1'b0, int_valid, standby_release;
  logic [3:0] ack_wait = 4'h0, int_src;
  logic [15:0] int_vector;
  itp_kind_t int_kind;
  int n_mismatch = 0, n_tests = 0;

  always #50 clk_sys = ~clk_sys;

  itp_top itp_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .wdt_overflow(wdt_overflow),
    .wdt_nmi_mode(wdt_nmi_mode), .maskable_req(maskable_req), .mask_flags(mask_flags),
    .priority_group_flags_low(priority_group_flags_low), .priority_group_flags_high(priority_group_flags_high),
    .int_enable(int_enable), .software_trap_instruction(software_trap_instruction), .int_ack(int_ack),
    .int_return(int_return), .int_valid(int_valid), .int_kind(int_kind), .int_src(int_src),
    .int_vector(int_vector), .standby_release(standby_release));
  itp_core_model itp_core_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .int_valid(int_valid),
    .ack_en(ack_en), .ack_wait(ack_wait), .ret_req(ret_req), .int_ack(int_ack), .int_return(int_return));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Kind and source only mean something while a request is presented; otherwise the vector must read ITP_VEC_RST.
  task automatic expect_out(input logic v, input itp_kind_t k, input logic [3:0] s,
                            input logic [15:0] vec, input logic sb);
    `CHK("int_valid", v, int_valid)
    `CHK("standby_release", sb, standby_release)
    if (v) begin
      `CHK("int_kind", k, int_kind)
      `CHK("int_src", s, int_src)
    end
    `CHK("int_vector", (v ? vec : ITP_VEC_RST), int_vector)
  endtask

  // One-cycle request pulses; outputs are looked at once the taking edge has landed.
  task automatic pulse(input logic [9:0] m, input logic w, input logic t);
    @(posedge clk_sys);
    maskable_req <= m;
    wdt_overflow <= w;
    software_trap_instruction <= t;
    @(posedge clk_sys);
    maskable_req <= 10'h000;
    wdt_overflow <= 1'b0;
    software_trap_instruction <= 1'b0;
    #1;
  endtask

  // Let the core take the presented request; bounded so a missing request cannot hang.
  task automatic do_ack();
    int i;
    @(posedge clk_sys);
    ack_en <= 1'b1;
    for (i = 0; i < 20 && int_ack !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK("ack seen", 1'b1, int_ack)
    @(posedge clk_sys);
    ack_en <= 1'b0;
    #1;
  endtask

  task automatic do_ret();
    @(posedge clk_sys);
    ret_req <= 1'b1;
    @(posedge clk_sys);
    ret_req <= 1'b0;
    #1;
  endtask

  // Level inputs change at one edge and are seen by the design at the next.
  task automatic settle();
    @(posedge clk_sys);
    #1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // All ten sources at once come out strictly from 0 to 9, one per handler.
  task automatic test_order();
    pulse(10'h3FF, 1'b0, 1'b0);
    for (int i = 0; i < 10; i++) begin
      expect_out(1'b1, ITP_KIND_HIGH, 4'(i), 16'h0004 + 16'(2 * i), 1'b1);
      do_ack();
      expect_out(1'b0, ITP_KIND_NMI, 4'h0, 16'h0000, (i < 9));
      do_ret();
    end
  endtask

  // A masked or globally disabled source is held, not presented.
  task automatic test_mask();
    @(posedge clk_sys);
    mask_flags <= 10'h3FF;
    pulse(10'h010, 1'b0, 1'b0);
    expect_out(1'b0, ITP_KIND_NMI, 4'h0, 16'h0000, 1'b0);
    @(posedge clk_sys);
    mask_flags <= 10'h000;
    int_enable <= 1'b0;
    settle();
    expect_out(1'b0, ITP_KIND_NMI, 4'h0, 16'h0000, 1'b1);
    @(posedge clk_sys);
    int_enable <= 1'b1;
    settle();
    expect_out(1'b1, ITP_KIND_HIGH, 4'h4, 16'h000C, 1'b1);
    do_ack();
    do_ret();
  endtask

  // Watchdog, trap and a masked source together while disabled; slow core.
  task automatic test_nmi_trap();
    @(posedge clk_sys);
    ack_wait <= 4'h2;
    int_enable <= 1'b0;
    mask_flags <= 10'h3FF;
    wdt_nmi_mode <= 1'b1;
    pulse(10'h001, 1'b1, 1'b1);
    expect_out(1'b1, ITP_KIND_NMI, 4'h0, 16'h0004, 1'b1);
    do_ack();
    expect_out(1'b1, ITP_KIND_TRAP, 4'h0, 16'h003E, 1'b0);
    do_ack();
    do_ret();
    do_ret();
    expect_out(1'b0, ITP_KIND_NMI, 4'h0, 16'h0000, 1'b0);
    @(posedge clk_sys);
    mask_flags <= 10'h000;
    int_enable <= 1'b1;
    wdt_nmi_mode <= 1'b0;
    settle();
    expect_out(1'b1, ITP_KIND_HIGH, 4'h0, 16'h0004, 1'b1);
    do_ack();
    do_ret();
    pulse(10'h000, 1'b1, 1'b0);
    expect_out(1'b1, ITP_KIND_HIGH, 4'h0, 16'h0004, 1'b1);
    do_ack();
    do_ret();
    ack_wait <= 4'h0;
  endtask

  // Three-deep nesting: low, then high, then trap, with groups overriding index order.
  task automatic test_nest();
    @(posedge clk_sys);
    priority_group_flags_low <= 8'h80;
    priority_group_flags_high <= 2'b01;
    pulse(10'h080, 1'b0, 1'b0);
    expect_out(1'b1, ITP_KIND_LOW, 4'h7, 16'h0012, 1'b1);
    do_ack();
    pulse(10'h002, 1'b0, 1'b0);
    expect_out(1'b1, ITP_KIND_HIGH, 4'h1, 16'h0006, 1'b1);
    do_ack();
    pulse(10'h000, 1'b0, 1'b1);
    expect_out(1'b1, ITP_KIND_TRAP, 4'h0, 16'h003E, 1'b0);
    do_ack();
    do_ret();
    pulse(10'h300, 1'b0, 1'b0);
    expect_out(1'b0, ITP_KIND_NMI, 4'h0, 16'h0000, 1'b1);
    do_ret();
    expect_out(1'b1, ITP_KIND_HIGH, 4'h9, 16'h0016, 1'b1);
    do_ack();
    do_ret();
    expect_out(1'b0, ITP_KIND_NMI, 4'h0, 16'h0000, 1'b1);
    do_ret();
    expect_out(1'b1, ITP_KIND_LOW, 4'h8, 16'h0014, 1'b1);
    do_ack();
    do_ret();
    expect_out(1'b0, ITP_KIND_NMI, 4'h0, 16'h0000, 1'b0);
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence: reset for four cycles, then every scenario in turn.
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    expect_out(1'b0, ITP_KIND_NMI, 4'h0, 16'h0000, 1'b0);
    test_order();
    test_mask();
    test_nmi_trap();
    test_nest();
    conclude();
  end

  // The scenarios need well under a thousand cycles; thirty thousand means a hang.
  initial begin
    #3_000_000;
    n_mismatch++;
    conclude();
  end
endmodule // itp_top_tb
